// File: design/free_running_timer_output_compare.sv
// Purpose: 16-bit free-running timer with overflow flag and two output compares
// Assumes: REF_CLK 40 MHz, RST async active high, byte register port
// Notes:   EXT_TCLK and the compare level pins sit outside this clock domain
//
// Behaviour
// - sixteen-bit up-counter advances on every timer tick, read as two bytes
// - alternate count view shows same value, its low byte never clears overflow
// - low-byte write of either view and reset load fffc
// - tick is clock divided by 2, 4, 8 or external clock edge
// - select code 00 div4, 01 div2, 10 div8, 11 reserved
// - high-byte read latches the matching low byte for next low read
// - latched low byte holds until low read, repeated high reads keep it
// - after complete sequence a lone low read returns live low byte
// - rollover from ffff to 0000 sets overflow flag
// - overflow request needs flag, enable and clear cpu mask
// - overflow clears by status read seeing it then counter low access
// - wait mode leaves timer running, timer interrupt wakes from wait
// - halt stops counter, interrupt wake resumes, reset wake restarts
// - each compare value checked every tick, match sets channel flag
// - compare values fully read/write, untouched by hardware, reset 8000
// - match with pin enabled drives programmed level, pin low in reset
// - pin enable clear leaves pin as plain I/O, flag still works
// - compare request on any flag with enable and clear mask, shared line
// - compare flag clears by status read seeing it then compare low access
// - compare high write blocks matching until compare low is written
// - div2 matches at count equal, other rates at compare plus one
// - force with pin enabled copies level to pin, no flag, no request
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module free_running_timer_output_compare (
  input  wire logic                          REF_CLK,
  input  wire logic                          RST,
  input  wire logic [tmr_pkg::ADDR_W-1:0]    ADDR,
  input  wire logic [tmr_pkg::DATA_W-1:0]    WDATA,
  input  wire logic                          WR,
  input  wire logic                          RD,
  output logic      [tmr_pkg::DATA_W-1:0]    RDATA,
  input  wire logic                          CPU_IMASK,
  input  wire logic                          WAIT_MODE,
  input  wire logic                          HALT_MODE,
  input  wire logic                          EXT_TCLK,
  output logic                               IRQ,
  output logic                               WAKE,
  output logic      [tmr_pkg::NCH-1:0]       OCMP_OUT,
  output logic      [tmr_pkg::NCH-1:0]       OCMP_OE
);

  tmr_pkg::ctrl1_t                ctrl1_r;
  tmr_pkg::ctrl2_t                ctrl2_r;
  logic                           ext_sel_r;
  logic [tmr_pkg::CNT_W-1:0]      cnt_r;
  logic [tmr_pkg::CNT_W-1:0]      cnt_nxt;
  logic [tmr_pkg::PRE_W-1:0]      pre_r;
  logic                           ext_s1_r;
  logic                           ext_s2_r;
  logic                           ext_s3_r;
  logic                           ext_edge;
  logic                           int_tick;
  logic                           tick;
  logic                           tof_r;
  logic                           tof_arm_r;
  logic [tmr_pkg::DATA_W-1:0]     lo_latch_r;
  logic                           latched_r;
  logic [tmr_pkg::DATA_W-1:0]     rdata_nxt;
  logic                           rd_cnt_hi;
  logic                           rd_cnt_lo;
  logic                           cnt_lo_acc;
  logic                           cnt_lo_wr;
  logic                           st_rd;
  logic [tmr_pkg::CNT_W-1:0]      cmp_r   [tmr_pkg::NCH];
  logic [tmr_pkg::NCH-1:0]        flag_r;
  logic [tmr_pkg::NCH-1:0]        arm_r;
  logic [tmr_pkg::NCH-1:0]        inhib_r;
  logic [tmr_pkg::NCH-1:0]        pin_r;
  logic [tmr_pkg::NCH-1:0]        level;
  logic [tmr_pkg::NCH-1:0]        force_v;
  logic [tmr_pkg::NCH-1:0]        pen;
  logic [tmr_pkg::ADDR_W-1:0]     cmp_hi_ofs [tmr_pkg::NCH];
  logic [tmr_pkg::ADDR_W-1:0]     cmp_lo_ofs [tmr_pkg::NCH];
  logic                           div2_mode;
  logic                           ovf_req;
  logic                           cmp_req;

  // per-channel views of the control bits
  assign level      = {ctrl1_r.level2, ctrl1_r.level1};
  assign force_v    = {ctrl1_r.force2, ctrl1_r.force1};
  assign pen        = {ctrl2_r.pin_enable2, ctrl2_r.pin_enable1};
  assign cmp_hi_ofs = '{tmr_pkg::OFS_CMP1_HI, tmr_pkg::OFS_CMP2_HI};
  assign cmp_lo_ofs = '{tmr_pkg::OFS_CMP1_LO, tmr_pkg::OFS_CMP2_LO};

  // decoded accesses
  assign rd_cnt_hi  = RD && (ADDR == tmr_pkg::OFS_CNT_HI || ADDR == tmr_pkg::OFS_ALT_HI);
  assign rd_cnt_lo  = RD && (ADDR == tmr_pkg::OFS_CNT_LO || ADDR == tmr_pkg::OFS_ALT_LO);
  assign cnt_lo_wr  = WR && (ADDR == tmr_pkg::OFS_CNT_LO || ADDR == tmr_pkg::OFS_ALT_LO);
  assign cnt_lo_acc = (RD || WR) && ADDR == tmr_pkg::OFS_CNT_LO;
  assign st_rd      = RD && ADDR == tmr_pkg::OFS_STATUS;

  // control registers, reserved bits stay zero
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl1_r   <= '0;
      ctrl2_r   <= '0;
      ext_sel_r <= 1'b0;
    end else if (WR) begin
      if (ADDR == tmr_pkg::OFS_CTRL1) begin
        ctrl1_r       <= tmr_pkg::ctrl1_t'(WDATA);
        ctrl1_r.zero7 <= 1'b0;
        ctrl1_r.zero1 <= 1'b0;
      end
      if (ADDR == tmr_pkg::OFS_CTRL2) begin
        ctrl2_r        <= tmr_pkg::ctrl2_t'(WDATA);
        ctrl2_r.zero54 <= 2'b00;
        ctrl2_r.zero10 <= 2'b00;
      end
      if (ADDR == tmr_pkg::OFS_EXTSEL) begin
        ext_sel_r <= WDATA[0];
      end
    end
  end

  // external clock synchroniser, edge taken past second stage
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= EXT_TCLK;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end
  assign ext_edge = ext_s2_r && !ext_s3_r;

  // free-running prescaler, frozen in halt
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pre_r <= '0;
    end else if (!HALT_MODE) begin
      pre_r <= pre_r + tmr_pkg::PRE_ONE;
    end
  end

  // tick selection
  always_comb begin
    int_tick = 1'b0;
    case (ctrl2_r.prescale_select)
      tmr_pkg::CC_DIV2: int_tick = (pre_r & tmr_pkg::MASK_DIV2) == tmr_pkg::MASK_DIV2;
      tmr_pkg::CC_DIV4: int_tick = (pre_r & tmr_pkg::MASK_DIV4) == tmr_pkg::MASK_DIV4;
      tmr_pkg::CC_DIV8: int_tick = (pre_r & tmr_pkg::MASK_DIV8) == tmr_pkg::MASK_DIV8;
      tmr_pkg::CC_RSVD: int_tick = 1'b0;
      default:          int_tick = 1'b0;
    endcase
  end
  assign tick      = !HALT_MODE && (ext_sel_r ? ext_edge : int_tick);
  assign div2_mode = !ext_sel_r && ctrl2_r.prescale_select == tmr_pkg::CC_DIV2;
  assign cnt_nxt   = cnt_r + tmr_pkg::CNT_ONE;

  // the counter itself
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cnt_r <= tmr_pkg::CNT_RELOAD;
    end else if (cnt_lo_wr) begin
      cnt_r <= tmr_pkg::CNT_RELOAD;
    end else if (tick) begin
      cnt_r <= cnt_nxt;
    end
  end

  // overflow flag and its two-step clear, set wins
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tof_r     <= 1'b0;
      tof_arm_r <= 1'b0;
    end else begin
      if (tick && !cnt_lo_wr && cnt_r == tmr_pkg::CNT_MAX) begin
        tof_r <= 1'b1;
      end else if (cnt_lo_acc && tof_arm_r) begin
        tof_r <= 1'b0;
      end
      if (cnt_lo_acc) begin
        tof_arm_r <= 1'b0;
      end else if (st_rd && tof_r) begin
        tof_arm_r <= 1'b1;
      end
    end
  end

  // low-byte buffer for the 16-bit read sequence
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      lo_latch_r <= '0;
      latched_r  <= 1'b0;
    end else if (rd_cnt_hi && !latched_r) begin
      lo_latch_r <= cnt_r[7:0];
      latched_r  <= 1'b1;
    end else if (rd_cnt_lo) begin
      latched_r  <= 1'b0;
    end
  end

  // compare channels
  genvar i;
  generate
    for (i = 0; i < tmr_pkg::NCH; i++) begin : g_ch
      logic hit;
      logic hi_wr;
      logic lo_wr;
      logic lo_acc;

      assign hi_wr  = WR && ADDR == cmp_hi_ofs[i];
      assign lo_wr  = WR && ADDR == cmp_lo_ofs[i];
      assign lo_acc = (RD || WR) && ADDR == cmp_lo_ofs[i];
      // div2 flags as the count reaches the value, slower rates one count later
      assign hit    = tick && !inhib_r[i] && !cnt_lo_wr &&
                      (div2_mode ? cnt_nxt == cmp_r[i] : cnt_r == cmp_r[i]);

      // compare value and high-byte inhibit
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          cmp_r[i]   <= tmr_pkg::CMP_RESET;
          inhib_r[i] <= 1'b0;
        end else begin
          if (hi_wr) begin
            cmp_r[i][15:8] <= WDATA;
            inhib_r[i]     <= 1'b1;
          end
          if (lo_wr) begin
            cmp_r[i][7:0] <= WDATA;
            inhib_r[i]    <= 1'b0;
          end
        end
      end

      // match flag with two-step clear, set wins
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          flag_r[i] <= 1'b0;
          arm_r[i]  <= 1'b0;
        end else begin
          if (hit && !force_v[i]) begin
            flag_r[i] <= 1'b1;
          end else if (lo_acc && arm_r[i]) begin
            flag_r[i] <= 1'b0;
          end
          if (lo_acc) begin
            arm_r[i] <= 1'b0;
          end else if (st_rd && flag_r[i]) begin
            arm_r[i] <= 1'b1;
          end
        end
      end

      // pin latch, low during reset
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          pin_r[i] <= 1'b0;
        end else if (pen[i] && (force_v[i] || hit)) begin
          pin_r[i] <= level[i];
        end
      end
    end
  endgenerate

  // pin drive only while alternate function enabled
  assign OCMP_OUT = pin_r;
  assign OCMP_OE  = pen;

  // interrupt request and wait wake-up
  assign ovf_req = tof_r && ctrl1_r.overflow_irq_enable;
  assign cmp_req = (|flag_r) && ctrl1_r.compare_irq_enable;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      IRQ  <= 1'b0;
      WAKE <= 1'b0;
    end else begin
      IRQ  <= (ovf_req || cmp_req) && !CPU_IMASK;
      WAKE <= (ovf_req || cmp_req) && !CPU_IMASK && WAIT_MODE;
    end
  end

  // read mux
  always_comb begin
    rdata_nxt = tmr_pkg::BYTE_ZERO;
    case (ADDR)
      tmr_pkg::OFS_CTRL1:   rdata_nxt = ctrl1_r;
      tmr_pkg::OFS_CTRL2:   rdata_nxt = ctrl2_r;
      tmr_pkg::OFS_STATUS: begin
        rdata_nxt[tmr_pkg::ST_OCF1] = flag_r[0];
        rdata_nxt[tmr_pkg::ST_TOF]  = tof_r;
        rdata_nxt[tmr_pkg::ST_OCF2] = flag_r[1];
      end
      tmr_pkg::OFS_CMP1_HI: rdata_nxt = cmp_r[0][15:8];
      tmr_pkg::OFS_CMP1_LO: rdata_nxt = cmp_r[0][7:0];
      tmr_pkg::OFS_CMP2_HI: rdata_nxt = cmp_r[1][15:8];
      tmr_pkg::OFS_CMP2_LO: rdata_nxt = cmp_r[1][7:0];
      tmr_pkg::OFS_CNT_HI,
      tmr_pkg::OFS_ALT_HI:  rdata_nxt = cnt_r[15:8];
      tmr_pkg::OFS_CNT_LO,
      tmr_pkg::OFS_ALT_LO:  rdata_nxt = latched_r ? lo_latch_r : cnt_r[7:0];
      tmr_pkg::OFS_EXTSEL:  rdata_nxt = {7'h00, ext_sel_r};
      default:              rdata_nxt = tmr_pkg::BYTE_ZERO;
    endcase
  end

  // read data stands the cycle after the strobe
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= '0;
    end else if (RD) begin
      RDATA <= rdata_nxt;
    end else begin
      RDATA <= '0;
    end
  end

endmodule : free_running_timer_output_compare

// File: design/tmr_pkg.sv
// Purpose: shared constants and types of the 16-bit timer with two compares
// Assumes: byte-wide register port, one clock
// Notes:   offsets are register indexes on the plain port
package tmr_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned NCH    = 2;
  localparam int unsigned PRE_W  = 3;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL1    = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL2    = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_CMP1_HI  = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_CMP1_LO  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CNT_HI   = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_CNT_LO   = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_CMP2_HI  = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_ALT_HI   = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CMP2_LO  = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_ALT_LO   = 4'ha;
  localparam logic [ADDR_W-1:0] OFS_EXTSEL   = 4'hb;

  // reset and reload values
  localparam logic [CNT_W-1:0]  CNT_RELOAD   = 16'hfffc;
  localparam logic [CNT_W-1:0]  CNT_MAX      = 16'hffff;
  localparam logic [CNT_W-1:0]  CMP_RESET    = 16'h8000;
  localparam logic [CNT_W-1:0]  CNT_ONE      = 16'h0001;
  localparam logic [DATA_W-1:0] BYTE_ZERO    = 8'h00;

  // prescaler codes and terminal masks
  typedef enum logic [1:0] {
    CC_DIV4 = 2'b00,
    CC_DIV2 = 2'b01,
    CC_DIV8 = 2'b10,
    CC_RSVD = 2'b11
  } prescale_t;
  localparam logic [PRE_W-1:0] PRE_ONE   = 3'h1;
  localparam logic [PRE_W-1:0] MASK_DIV2 = 3'h1;
  localparam logic [PRE_W-1:0] MASK_DIV4 = 3'h3;
  localparam logic [PRE_W-1:0] MASK_DIV8 = 3'h7;

  // status bit positions
  localparam int unsigned ST_OCF1 = 6;
  localparam int unsigned ST_TOF  = 5;
  localparam int unsigned ST_OCF2 = 3;

  // control one layout
  typedef struct packed {
    logic zero7;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic force2;
    logic force1;
    logic level2;
    logic zero1;
    logic level1;
  } ctrl1_t;

  // control two layout
  typedef struct packed {
    logic      pin_enable1;
    logic      pin_enable2;
    logic [1:0] zero54;
    prescale_t prescale_select;
    logic [1:0] zero10;
  } ctrl2_t;

endpackage : tmr_pkg

// File: tb/pin_board.sv
// Purpose: board side of the two compare pins
// Assumes: pins carry pull-ups
// Notes:   level is what the outside world sees
`timescale 1ns/1ps
module pin_board (
  input  wire logic [tmr_pkg::NCH-1:0] pin_out,
  input  wire logic [tmr_pkg::NCH-1:0] pin_oe,
  output logic      [tmr_pkg::NCH-1:0] pin_level
);
  // driven latch when enabled, pull-up when free
  always_comb begin
    for (int i = 0; i < tmr_pkg::NCH; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : 1'b1;
    end
  end
endmodule : pin_board

// File: tb/tb_top.sv
// Purpose: self-checking bench of the timer
// Assumes: counter frozen by halt between checks
// Notes:   counts read after a run allow one tick of slack
`timescale 1ns/1ps
module tb_top;
  logic                       ref_clk;
  logic                       rst;
  logic [tmr_pkg::ADDR_W-1:0] addr;
  logic [7:0]                 wdata;
  logic                       wr;
  logic                       rd;
  logic [7:0]                 rdata;
  logic                       imask;
  logic                       wait_mode;
  logic                       halt;
  logic                       ext_clk;
  logic                       irq;
  logic                       wake;
  logic [1:0]                 ocmp_out;
  logic [1:0]                 ocmp_oe;
  logic [1:0]                 pin;
  logic [7:0]                 v;
  int                         bad_count;
  int                         checks;
  int                         cyc = 0;
  tmr_pkg::prescale_t         codes [3] = '{tmr_pkg::CC_DIV2, tmr_pkg::CC_DIV4, tmr_pkg::CC_DIV8};
  int                         divs [3] = '{2, 4, 8};
  logic [3:0]                 cmp_a [4] = '{4'h3, 4'h4, 4'h7, 4'h9};
  logic [7:0]                 cmp_r [4] = '{8'h80, 8'h00, 8'h80, 8'h00};

  free_running_timer_output_compare uut (.REF_CLK(ref_clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CPU_IMASK(imask),
    .WAIT_MODE(wait_mode), .HALT_MODE(halt), .EXT_TCLK(ext_clk), .IRQ(irq), .WAKE(wake),
    .OCMP_OUT(ocmp_out), .OCMP_OE(ocmp_oe));
  pin_board pb (.pin_out(ocmp_out), .pin_oe(ocmp_oe), .pin_level(pin));

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic chk_near(input string nm, input logic [7:0] exp, input logic [7:0] got);
    chk(nm, (got === exp + 8'h01 || got === exp - 8'h01) ? got : exp, got);
  endtask : chk_near
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk(nm, exp, d);
  endtask : rd_chk
  task automatic run(input int n);
    @(posedge ref_clk);
    halt <= 1'b0;
    repeat (n) @(posedge ref_clk);
    halt <= 1'b1;
  endtask : run

  // main sequence
  initial begin
    rst = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    imask = 1'b0;
    wait_mode = 1'b1;
    halt = 1'b1;
    ext_clk = 1'b0;
    bad_count = 0;
    checks = 0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values, counter frozen
    rd_chk("cnt_hi", tmr_pkg::OFS_CNT_HI, 8'hff);
    rd_chk("cnt_lo", tmr_pkg::OFS_CNT_LO, 8'hfc);
    foreach (cmp_a[i]) rd_chk("cmp_rst", cmp_a[i], cmp_r[i]);
    rd_chk("status", tmr_pkg::OFS_STATUS, 8'h00);
    rd_chk("unmapped", 4'hc, 8'h00);
    chk("pin2_free", 8'h01, {7'h0, pin[1]});
    // each rate from reload, overflow and its clearing
    for (int i = 0; i < 3; i++) begin
      wr_reg(tmr_pkg::OFS_CTRL2, {4'h0, codes[i], 2'b00});
      wr_reg(tmr_pkg::OFS_CNT_LO, 8'h5a);
      run(48);
      rd_chk("st_ovf", tmr_pkg::OFS_STATUS, 8'h20);
      rd_chk("alt_hi", tmr_pkg::OFS_ALT_HI, 8'h00);
      rd_reg(tmr_pkg::OFS_ALT_LO, v);
      chk_near("alt_lo", 8'hfc + 8'(48 / divs[i]), v);
      rd_chk("st_kept", tmr_pkg::OFS_STATUS, 8'h20);
      rd_reg(tmr_pkg::OFS_CNT_LO, v);
      rd_chk("st_clr", tmr_pkg::OFS_STATUS, 8'h00);
    end
    // external clock: four slow edges from reload reach 0000
    wr_reg(tmr_pkg::OFS_EXTSEL, 8'h01);
    wr_reg(tmr_pkg::OFS_CNT_LO, 8'h00);
    @(posedge ref_clk);
    halt <= 1'b0;
    repeat (4) begin
      ext_clk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ext_clk <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
    halt <= 1'b1;
    rd_chk("ext_hi", tmr_pkg::OFS_CNT_HI, 8'h00);
    rd_chk("ext_lo", tmr_pkg::OFS_CNT_LO, 8'h00);
    wr_reg(tmr_pkg::OFS_EXTSEL, 8'h00);
    // reserved code holds the count
    wr_reg(tmr_pkg::OFS_CTRL2, 8'h0c);
    wr_reg(tmr_pkg::OFS_CNT_LO, 8'h00);
    run(48);
    rd_chk("rsv_hi", tmr_pkg::OFS_CNT_HI, 8'hff);
    rd_chk("rsv_lo", tmr_pkg::OFS_CNT_LO, 8'hfc);
    // latched low byte survives running and a second high read
    wr_reg(tmr_pkg::OFS_CTRL2, 8'h04);
    rd_chk("hi_first", tmr_pkg::OFS_CNT_HI, 8'hff);
    run(32);
    rd_chk("hi_again", tmr_pkg::OFS_CNT_HI, 8'h00);
    rd_chk("lo_latched", tmr_pkg::OFS_CNT_LO, 8'hfc);
    rd_reg(tmr_pkg::OFS_CNT_LO, v);
    chk_near("lo_live", 8'h0c, v);
    rd_reg(tmr_pkg::OFS_STATUS, v);
    wr_reg(tmr_pkg::OFS_CNT_LO, 8'h00);
    // compare one at 0008, compare two inhibited at 0000
    wr_reg(tmr_pkg::OFS_CTRL2, 8'h84);
    wr_reg(tmr_pkg::OFS_CTRL1, 8'h41);
    wr_reg(tmr_pkg::OFS_CMP2_HI, 8'h00);
    wr_reg(tmr_pkg::OFS_CMP1_HI, 8'h00);
    rd_reg(tmr_pkg::OFS_STATUS, v);
    wr_reg(tmr_pkg::OFS_CMP1_LO, 8'h08);
    rd_chk("cmp1_lo", tmr_pkg::OFS_CMP1_LO, 8'h08);
    imask <= 1'b1;
    halt <= 1'b0;
    for (int n = 0; n < 100 && pin[0] !== 1'b1; n++) @(posedge ref_clk);
    #1 chk("pin1", 8'h01, {7'h0, pin[0]});
    chk("irq_masked", 8'h00, {7'h0, irq});
    @(posedge ref_clk);
    imask <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("irq", 8'h01, {7'h0, irq});
    chk("wake", 8'h01, {7'h0, wake});
    halt <= 1'b1;
    rd_chk("st_cmp", tmr_pkg::OFS_STATUS, 8'h60);
    rd_reg(tmr_pkg::OFS_CMP1_LO, v);
    rd_chk("st_cmp_clr", tmr_pkg::OFS_STATUS, 8'h20);
    chk("irq_gone", 8'h00, {7'h0, irq});
    // forced level follows the control bit
    wr_reg(tmr_pkg::OFS_CTRL1, 8'h08);
    repeat (2) @(posedge ref_clk);
    #1 chk("force_lo", 8'h00, {7'h0, pin[0]});
    wr_reg(tmr_pkg::OFS_CTRL1, 8'h09);
    repeat (2) @(posedge ref_clk);
    #1 chk("force_hi", 8'h01, {7'h0, pin[0]});
    rd_chk("st_force", tmr_pkg::OFS_STATUS, 8'h20);
    // reserved control bits read zero
    wr_reg(tmr_pkg::OFS_CTRL1, 8'hff);
    rd_chk("ctrl1", tmr_pkg::OFS_CTRL1, 8'h7d);
    wr_reg(tmr_pkg::OFS_CTRL2, 8'hff);
    rd_chk("ctrl2", tmr_pkg::OFS_CTRL2, 8'hcc);
    print_verdict();
  end
endmodule : tb_top

// File: tb/tmr_checker.sv
// Purpose: port checker of the timer
// Assumes: one clock, RST async high
// Notes:   bound to the top module
`timescale 1ns/1ps
module tmr_checker (
  input wire logic                       REF_CLK,
  input wire logic                       RST,
  input wire logic [tmr_pkg::ADDR_W-1:0] ADDR,
  input wire logic                       WR,
  input wire logic                       RD,
  input wire logic [tmr_pkg::DATA_W-1:0] RDATA,
  input wire logic                       CPU_IMASK,
  input wire logic                       WAIT_MODE,
  input wire logic                       IRQ,
  input wire logic                       WAKE,
  input wire logic [tmr_pkg::NCH-1:0]    OCMP_OUT,
  input wire logic [tmr_pkg::NCH-1:0]    OCMP_OE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // read port and register shape
  property p_rd_idle; !RD |=> RDATA == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_st_rsvd; RD && ADDR == tmr_pkg::OFS_STATUS |=> (RDATA & 8'h97) == 8'h00; endproperty
  a_st_rsvd: assert property (p_st_rsvd) else $error("status reserved bit set");
  property p_unmap; RD && ADDR > tmr_pkg::OFS_EXTSEL |=> RDATA == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // request gating and wake
  property p_mask; CPU_IMASK |=> !IRQ; endproperty
  a_mask: assert property (p_mask) else $error("request while masked");
  property p_wake_cause; WAKE |-> $past(WAIT_MODE) && IRQ; endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without cause");
  property p_wake_follow; $past(WAIT_MODE) && IRQ |-> WAKE; endproperty
  a_wake_follow: assert property (p_wake_follow) else $error("wake missing");
  // pins move only while enabled, enables only by control write
  property p_pin1; !OCMP_OE[0] |=> $stable(OCMP_OUT[0]); endproperty
  a_pin1: assert property (p_pin1) else $error("pin one moved while free");
  property p_pin2; !OCMP_OE[1] |=> $stable(OCMP_OUT[1]); endproperty
  a_pin2: assert property (p_pin2) else $error("pin two moved while free");
  property p_oe; $changed(OCMP_OE) |-> $past(WR && ADDR == tmr_pkg::OFS_CTRL2); endproperty
  a_oe: assert property (p_oe) else $error("pin enable changed alone");
  c_irq: cover property ($rose(IRQ));
  c_wake: cover property (WAKE);
  c_pin: cover property ($rose(OCMP_OUT[0]));
endmodule : tmr_checker

bind free_running_timer_output_compare tmr_checker chk (.REF_CLK(REF_CLK), .RST(RST),
  .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA), .CPU_IMASK(CPU_IMASK),
  .WAIT_MODE(WAIT_MODE), .IRQ(IRQ), .WAKE(WAKE), .OCMP_OUT(OCMP_OUT), .OCMP_OE(OCMP_OE));
